// ===== bench/pao_dialer.sv
// pao_dialer: report receiver model, counts alarm and restore pulses.
// assumes one-cycle report pulses on the aclk domain.
`timescale 1ns/1ps
`default_nettype none
module pao_dialer import pao_pkg::*; (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // reports from the block
  input wire logic [NP-1:0] rep_alarm,
  input wire logic [NP-1:0] rep_restore,
  // counts seen
  output int alarm_cnt,
  output int restore_cnt
);
  // ==========================================================
  // pulse counters
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_cnt <= 0;
      restore_cnt <= 0;
    end else begin
      alarm_cnt <= alarm_cnt + int'(rep_alarm[0]) + int'(rep_alarm[1]);
      restore_cnt <= restore_cnt + int'(rep_restore[0]) + int'(rep_restore[1]);
    end
  end
endmodule : pao_dialer
`default_nettype wire

// ===== bench/test_partition_arming_options.sv
// test_partition_arming_options: self-checking bench of pao_top.
// assumes TICK_CYC=4, so one second is 16 aclk cycles.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin failures++; \
  $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end
module test_partition_arming_options import pao_pkg::*;;
  logic aclk = 0, aresetn = 0;
  logic [7:0] s_awaddr = 0, s_araddr = 0;
  logic [31:0] s_wdata = 0, s_rdata;
  logic [3:0] s_wstrb = 0;
  logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
  logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid, irq;
  logic [1:0] s_bresp, s_rresp;
  logic [NP-1:0] door_open = 0, int_open = 0, burg_zone = 0, zone_24h = 0, bell_done = 0;
  logic [NP-1:0] armed, sounder, bypass, rep_alarm, rep_restore;
  int alarm_cnt, restore_cnt, failures = 0, compares = 0;
  logic [31:0] rd;
  logic [1:0] rs;
  // ==========================================================
  // clock, design and dialer model
  always #2.5 aclk = ~aclk;
  pao_top #(.TICK_CYC(4)) i_dut (.aclk(aclk), .aresetn(aresetn), .s_awaddr(s_awaddr),
    .s_awvalid(s_awvalid), .s_awready(s_awready), .s_wdata(s_wdata), .s_wstrb(s_wstrb),
    .s_wvalid(s_wvalid), .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
    .s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
    .door_open(door_open), .int_open(int_open), .burg_zone(burg_zone), .zone_24h(zone_24h),
    .bell_done(bell_done), .armed(armed), .sounder(sounder), .bypass(bypass),
    .rep_alarm(rep_alarm), .rep_restore(rep_restore), .irq(irq));
  pao_dialer i_dial (.aclk(aclk), .aresetn(aresetn), .rep_alarm(rep_alarm),
    .rep_restore(rep_restore), .alarm_cnt(alarm_cnt), .restore_cnt(restore_cnt));
  // ==========================================================
  // bus tasks
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic awd, wd;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'hF;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    awd = 0;
    wd = 0;
    while (!(awd && wd)) begin
      @(posedge aclk);
      if (!awd && s_awready === 1'b1) begin
        awd = 1;
        s_awvalid <= 1'b0;
      end
      if (!wd && s_wready === 1'b1) begin
        wd = 1;
        s_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_bvalid !== 1'b1);
    s_bready <= 1'b0;
  endtask : wr
  task automatic rdw(input logic [7:0] a);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(posedge aclk); while (s_arready !== 1'b1);
    s_arvalid <= 1'b0;
    while (s_rvalid !== 1'b1) @(posedge aclk);
    rd = s_rdata;
    rs = s_rresp;
    s_rready <= 1'b0;
  endtask : rdw
  task automatic wait_bit(input int idx, input logic v, input int lim);
    int n;
    n = 0;
    while (armed[idx] !== v && n < lim) begin
      @(posedge aclk);
      n++;
    end
    `CHK(armed[idx], v)
  endtask : wait_bit
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rdw(OPT_OFF);
    `CHK(rd[7:0], 8'h11)
    rdw(ACC1_OFF);
    `CHK(rd[15:0], 16'hFFFF)
    rdw(CFG_OFF);
    `CHK(rd[5:0], 6'h00)
    rdw(8'h40);
    `CHK(rs, RESP_SLVERR)
    `CHK(rd, 32'h0000_0000)
  endtask : t_reset
  task automatic t_acct();
    wr(ACC0_OFF, 32'h0001_B905);
    rdw(ACC0_OFF);
    `CHK(rd[16:0], 17'h1B905)
    wr(ACC0_OFF, 32'h0001_A905);
    rdw(ACC0_OFF);
    `CHK(rd[16:0], 17'h1B905)
    rdw(ACC1_OFF);
    `CHK(rd[15:0], 16'hFFFF)
    wr(CMD_OFF, 32'h0000_0010);
    rdw(ACC0_OFF);
    `CHK({rd[17], rd[15:0]}, 17'h1FFFF)
  endtask : t_acct
  task automatic t_lobby_refuse();
    wr(CFG_OFF, 32'h0000_0008);
    wr(OPT_OFF, 32'h0000_001F);
    wr(CMD_OFF, 32'h0000_0002);
    repeat (20) @(posedge aclk);
    `CHK(armed[1], 1'b0)
    rdw(EVT_OFF);
    `CHK(rd[5], 1'b1)
    wr(EVCLR_OFF, 32'h0000_0030);
  endtask : t_lobby_refuse
  task automatic t_lobby_auto();
    wr(CMD_OFF, 32'h0000_0001);
    wait_bit(0, 1'b1, 1200);
    wait_bit(1, 1'b1, 1200);
  endtask : t_lobby_auto
  task automatic t_burg();
    int n, a0;
    wr(EVEN_OFF, 32'h0000_0001);
    a0 = alarm_cnt;
    burg_zone <= 2'b01;
    n = 0;
    while (alarm_cnt == a0 && n < 400) begin
      @(posedge aclk);
      n++;
    end
    `CHK(n >= 16 * 15 && n <= 16 * 17 + 8, 1'b1)
    `CHK(irq, 1'b1)
    wr(EVCLR_OFF, 32'h0000_0001);
    repeat (2) @(posedge aclk);
    `CHK(irq, 1'b0)
    a0 = restore_cnt;
    burg_zone <= 2'b00;
    repeat (12) @(posedge aclk);
    `CHK(restore_cnt, a0 + 1)
  endtask : t_burg
  task automatic t_lobby_drop();
    wr(CMD_OFF, 32'h0000_0004);
    repeat (6) @(posedge aclk);
    `CHK(armed, 2'b00)
  endtask : t_lobby_drop
  task automatic t_exit();
    int n, h;
    logic pv;
    wr(CFG_OFF, 32'h0000_0030);
    wr(OPT_OFF, 32'h0000_000F);
    door_open <= 2'b01;
    int_open <= 2'b01;
    wr(CMD_OFF, 32'h0000_0003);
    repeat (200) @(posedge aclk);
    door_open <= 2'b00;
    n = 0;
    while (bypass[0] !== 1'b1 && n < 1100) begin
      @(posedge aclk);
      n++;
    end
    `CHK(n >= 59 * 16 && n <= 61 * 16 + 8, 1'b1)
    `CHK(bypass, 2'b01)
    rdw(EVT_OFF);
    `CHK(rd[7:6], 2'b01)
    door_open <= 2'b10;
    h = 0;
    pv = 1'b0;
    repeat (64) begin
      @(posedge aclk);
      if (sounder[1] === 1'b1 && !pv) h++;
      pv = sounder[1];
    end
    `CHK(h, 3)
    wr(OPT_OFF, 32'h0000_001F);
    door_open <= 2'b00;
    repeat (440) @(posedge aclk);
    door_open <= 2'b10;
    repeat (8) @(posedge aclk);
    h = 0;
    repeat (64) begin
      @(posedge aclk);
      if (sounder[1] === 1'b1) h++;
    end
    `CHK(h, 16)
    wr(CFG_OFF, 32'h0000_0032);
    n = restore_cnt;
    burg_zone <= 2'b01;
    repeat (8) @(posedge aclk);
    burg_zone <= 2'b00;
    repeat (8) @(posedge aclk);
    `CHK(restore_cnt, n)
    wr(CMD_OFF, 32'h0000_000C);
    repeat (6) @(posedge aclk);
    `CHK(restore_cnt, n + 1)
  endtask : t_exit
  // ==========================================================
  // verdict and sequence
  task automatic final_report();
    $display("compares=%0d failures=%0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_acct();
    t_lobby_refuse();
    t_lobby_auto();
    t_burg();
    t_lobby_drop();
    t_exit();
    final_report();
  end
  initial begin
    repeat (20000) @(posedge aclk);
    failures++;
    final_report();
  end
endmodule : test_partition_arming_options
`default_nettype wire

// ===== inc/pao_pkg.sv
// pao_pkg: register map, field positions, reset values, timing and types
// for the partition arming options block.
// assumes a 200 MHz aclk and a 32-bit AXI4-Lite register bus.
package pao_pkg;
  // ==========================================================
  // sizes
  localparam int NP = 2;
  localparam int CNT_W = 7;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] CFG_OFF = 8'h00;
  localparam logic [7:0] OPT_OFF = 8'h04;
  localparam logic [7:0] ACC0_OFF = 8'h08;
  localparam logic [7:0] ACC1_OFF = 8'h0C;
  localparam logic [7:0] CMD_OFF = 8'h10;
  localparam logic [7:0] STAT_OFF = 8'h14;
  localparam logic [7:0] EVT_OFF = 8'h18;
  localparam logic [7:0] EVCLR_OFF = 8'h1C;
  localparam logic [7:0] EVEN_OFF = 8'h20;
  // ==========================================================
  // field positions
  localparam int CFG_RMODE_LSB = 0;
  localparam int CFG_LOB_LSB = 2;
  localparam int CFG_EXERR_BIT = 4;
  localparam int CFG_EXRST_BIT = 5;
  localparam int OPT_W = 4;
  localparam int ACC_SHORT_BIT = 16;
  localparam int ACC_EMPTY_BIT = 17;
  localparam int CMD_ARM_LSB = 0;
  localparam int CMD_DIS_LSB = 2;
  localparam int CMD_ERA_LSB = 4;
  localparam int EV_ALM_LSB = 0;
  localparam int EV_RST_LSB = 2;
  localparam int EV_REF_LSB = 4;
  localparam int EV_BYP_LSB = 6;
  localparam int EV_W = 8;
  // ==========================================================
  // reset values and codes
  localparam logic ENTRY_WARN_RST = 1'b1;
  localparam logic FLAG_RST = 1'b0;
  localparam logic [3:0] DIG_RST = 4'hF;
  localparam logic [3:0] DIG_DEC_MAX = 4'h9;
  localparam logic [3:0] DIG_HEX_MIN = 4'hB;
  localparam logic [1:0] RMODE_NOW = 2'h0;
  localparam logic [1:0] RMODE_BELL = 2'h1;
  localparam logic [1:0] RMODE_DISARM = 2'h2;
  localparam logic [1:0] LOB_NONE = 2'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // timing
  localparam int CLK_HZ = 200_000_000;
  localparam int QTR_PER_S = 4;
  localparam int QTR_CYC = CLK_HZ / QTR_PER_S;
  localparam logic [CNT_W-1:0] BURG_DLY_S = 7'd16;
  localparam logic [CNT_W-1:0] EXIT_S = 7'd60;
  localparam logic [CNT_W-1:0] EXIT_RST_S = 7'd60;
  localparam logic [CNT_W-1:0] ENTRY_S = 7'd30;
  localparam logic [3:0] BEEP_QTRS = 4'h6;
  // ==========================================================
  // types
  typedef struct packed {
    logic arms;
    logic affects;
    logic burg_dly;
    logic entry_warn;
  } pao_opt_s;
  typedef struct packed {
    logic short3;
    logic [3:0] d3;
    logic [3:0] d2;
    logic [3:0] d1;
    logic [3:0] d0;
  } pao_acct_s;
  typedef enum {PAO_IDLE, PAO_EXIT, PAO_ARMED, PAO_ENTRY} pao_ph_e;
endpackage : pao_pkg

// ===== verilog/pao_top.sv
// pao_top: per-partition option logic, arming, lobby, delays and reports.
// assumes zone pins are asynchronous levels; software on AXI4-Lite.
//
// Register access over AXI4-Lite and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - warn 0: three short beeps at entry; warn 1: slow beeps whole entry.
// - burg delay 1: hold burglary report 16 s; 24-hour zones never held.
// - restore mode 0: restore report as soon as zone returns normal.
// - restore mode 1: report at bell timeout, only if zone restored.
// - restore mode 2: restore report waits until partition disarms.
// - account digits 0-9 decimal, 11-15 hex B-F, others refused.
// - short flag set: last digit empty, account three digits long.
// - erase command clears a partition's secondary account field.
// - lobby selector 1 or 2 names lobby partition; 0 means none.
// - warn, delay, account, affects, arms options kept per partition.
// - lobby arm refused while any affecting partition is disarmed.
// - disarming an affecting partition also disarms the lobby.
// - arming a lobby-arming partition attempts to arm the lobby.
// - auto lobby arm succeeds only if other affecting ones armed.
// - arms flag honoured only when affects flag also set.
// - exit error on: open door and interior zones bypassed at exit end.
// - exit reset on: door closing in exit delay reloads 60 s.
module pao_top import pao_pkg::*; #(
  parameter int TICK_CYC = QTR_CYC
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // axi4-lite write
  input wire logic [7:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read
  input wire logic [7:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready,
  // zone pins
  input wire logic [NP-1:0] door_open,
  input wire logic [NP-1:0] int_open,
  input wire logic [NP-1:0] burg_zone,
  input wire logic [NP-1:0] zone_24h,
  input wire logic [NP-1:0] bell_done,
  // partition outputs
  output logic [NP-1:0] armed,
  output logic [NP-1:0] sounder,
  output logic [NP-1:0] bypass,
  output logic [NP-1:0] rep_alarm,
  output logic [NP-1:0] rep_restore,
  output logic irq
);
  // ==========================================================
  // registers and state
  logic [1:0] rmode_r, lob_r;
  logic exerr_r, exrst_r;
  pao_opt_s opt_r [NP];
  pao_acct_s acc_r [NP];
  logic [NP-1:0] empty_r;
  logic [EV_W-1:0] evt_r, even_r;
  pao_ph_e ph_r [NP];
  logic [CNT_W-1:0] ex_cnt_r [NP], en_cnt_r [NP], dly_cnt_r [NP];
  logic [3:0] bq_r [NP];
  logic [NP-1:0] armed_r, byp_r, snd_r, dly_r, seen_r, rstd_r;
  logic [NP-1:0] rep_a_r, rep_r_r;
  logic [NP-1:0] s1_door, s2_door, s1_int, s2_int, s1_bz, s2_bz;
  logic [NP-1:0] s1_24, s2_24, s1_bell, s2_bell;
  logic [NP-1:0] d_door, d_bz, d_bell;
  logic [31:0] q_cnt_r;
  logic [1:0] qph_r;
  logic q_tick, s_tick;
  logic aw_ok_r, w_ok_r, bv_r, rv_r;
  logic [7:0] awa_r;
  logic [31:0] wd_r, rd_r;
  logic [1:0] rresp_r, bresp_r;
  logic wr_go;
  logic [3:0] ws_r;
  logic [NP-1:0] byp_d_r;
  logic [NP-1:0] cmd_arm, cmd_dis, cmd_era;
  logic [EV_W-1:0] ev_clr, ev_set;
  // ==========================================================
  // helpers
  function automatic logic dig_ok(input logic [3:0] d);
    dig_ok = (d <= DIG_DEC_MAX) || (d >= DIG_HEX_MIN);
  endfunction : dig_ok
  function automatic logic [3:0] dig_pick(input logic [3:0] n, input logic [3:0] o);
    dig_pick = dig_ok(n) ? n : o;
  endfunction : dig_pick
  // ==========================================================
  // pin synchronisers
  always_ff @(posedge aclk) begin
    s1_door <= door_open;
    s2_door <= s1_door;
    s1_int <= int_open;
    s2_int <= s1_int;
    s1_bz <= burg_zone;
    s2_bz <= s1_bz;
    s1_24 <= zone_24h;
    s2_24 <= s1_24;
    s1_bell <= bell_done;
    s2_bell <= s1_bell;
    d_door <= s2_door;
    d_bz <= s2_bz;
    d_bell <= s2_bell;
  end
  // ==========================================================
  // quarter and one-second ticks
  assign q_tick = (q_cnt_r == 32'(TICK_CYC - 1));
  assign s_tick = q_tick && (qph_r == 2'h3);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_cnt_r <= '0;
      qph_r <= '0;
    end else if (q_tick) begin
      q_cnt_r <= '0;
      qph_r <= qph_r + 2'h1;
    end else begin
      q_cnt_r <= q_cnt_r + 32'h1;
    end
  end
  // ==========================================================
  // axi4-lite write channel
  assign wr_go = aw_ok_r && w_ok_r && !bv_r;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_ok_r <= 1'b0;
      w_ok_r <= 1'b0;
      bv_r <= 1'b0;
      awa_r <= '0;
      wd_r <= '0;
      ws_r <= '0;
      bresp_r <= RESP_OKAY;
    end else begin
      if (s_awvalid && !aw_ok_r) begin
        aw_ok_r <= 1'b1;
        awa_r <= s_awaddr;
      end
      if (s_wvalid && !w_ok_r) begin
        w_ok_r <= 1'b1;
        wd_r <= s_wdata;
        ws_r <= s_wstrb; // lanes kept with the data they qualify
      end
      if (wr_go) begin
        aw_ok_r <= 1'b0;
        w_ok_r <= 1'b0;
        bv_r <= 1'b1;
        case (awa_r)
          CFG_OFF, OPT_OFF, ACC0_OFF, ACC1_OFF, CMD_OFF, EVCLR_OFF,
          EVEN_OFF: bresp_r <= RESP_OKAY;
          default: bresp_r <= RESP_SLVERR;
        endcase
      end else if (bv_r && s_bready) begin
        bv_r <= 1'b0;
      end
    end
  end
  // command strobes from the write channel
  always_comb begin
    cmd_arm = '0;
    cmd_dis = '0;
    cmd_era = '0;
    ev_clr = '0;
    if (wr_go && awa_r == CMD_OFF && ws_r[0]) begin
      cmd_arm = wd_r[CMD_ARM_LSB +: NP];
      cmd_dis = wd_r[CMD_DIS_LSB +: NP];
      cmd_era = wd_r[CMD_ERA_LSB +: NP];
    end
    if (wr_go && awa_r == EVCLR_OFF && ws_r[0]) begin
      ev_clr = wd_r[EV_W-1:0];
    end
  end
  // ==========================================================
  // configuration registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rmode_r <= RMODE_NOW;
      lob_r <= LOB_NONE;
      exerr_r <= FLAG_RST;
      exrst_r <= FLAG_RST;
      even_r <= '0;
      for (int p = 0; p < NP; p++) begin
        opt_r[p] <= '{FLAG_RST, FLAG_RST, FLAG_RST, ENTRY_WARN_RST};
      end
    end else if (wr_go && ws_r[0]) begin
      case (awa_r)
        CFG_OFF: begin
          rmode_r <= wd_r[CFG_RMODE_LSB +: 2];
          lob_r <= wd_r[CFG_LOB_LSB +: 2];
          exerr_r <= wd_r[CFG_EXERR_BIT];
          exrst_r <= wd_r[CFG_EXRST_BIT];
        end
        OPT_OFF: begin
          for (int p = 0; p < NP; p++) begin
            opt_r[p] <= wd_r[p*OPT_W +: OPT_W];
          end
        end
        EVEN_OFF: even_r <= wd_r[EV_W-1:0];
        default: ;
      endcase
    end
  end
  // ==========================================================
  // secondary account digits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < NP; p++) begin
        acc_r[p] <= '{1'b0, DIG_RST, DIG_RST, DIG_RST, DIG_RST};
        empty_r[p] <= 1'b0;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        if (cmd_era[p]) begin
          acc_r[p] <= '{1'b0, DIG_RST, DIG_RST, DIG_RST, DIG_RST};
          empty_r[p] <= 1'b1;
        end else if (wr_go && awa_r == (p == 0 ? ACC0_OFF : ACC1_OFF)) begin
          if (ws_r[0]) begin
            acc_r[p].d0 <= dig_pick(wd_r[3:0], acc_r[p].d0);
            acc_r[p].d1 <= dig_pick(wd_r[7:4], acc_r[p].d1);
          end
          if (ws_r[1]) begin
            acc_r[p].d2 <= dig_pick(wd_r[11:8], acc_r[p].d2);
            acc_r[p].d3 <= dig_pick(wd_r[15:12], acc_r[p].d3);
          end
          if (ws_r[2]) begin
            acc_r[p].short3 <= wd_r[ACC_SHORT_BIT];
            empty_r[p] <= 1'b0;
          end
        end
      end
    end
  end
  // ==========================================================
  // lobby arbitration
  logic lob_en;
  logic lp;
  logic lob_ok;
  logic [NP-1:0] arm_go, dis_go, refuse, arm_rise;
  always_comb begin
    lob_en = (lob_r == 2'h1) || (lob_r == 2'h2);
    lp = lob_r[1];
    lob_ok = 1'b1;
    arm_go = '0;
    dis_go = cmd_dis;
    refuse = '0;
    arm_rise = armed_r & ~armed;
    for (int p = 0; p < NP; p++) begin
      if (lob_en && p != int'(lp) && opt_r[p].affects && !armed_r[p]) begin
        lob_ok = 1'b0;
      end
    end
    for (int p = 0; p < NP; p++) begin
      if (cmd_arm[p] && !armed_r[p]) begin
        if (lob_en && p == int'(lp) && !lob_ok) refuse[p] = 1'b1;
        else arm_go[p] = 1'b1;
      end
      if (lob_en && p != int'(lp) && cmd_dis[p] && opt_r[p].affects) begin
        dis_go[lp] = 1'b1;
      end
      if (lob_en && p != int'(lp) && arm_rise[p] && opt_r[p].affects
          && opt_r[p].arms && !armed_r[lp] && lob_ok) begin
        arm_go[lp] = 1'b1;
      end
    end
    arm_go = arm_go & ~dis_go;
  end
  // ==========================================================
  // arming phases, exit and entry delays, sounder
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      armed_r <= '0;
      byp_r <= '0;
      snd_r <= '0;
      for (int p = 0; p < NP; p++) begin
        ph_r[p] <= PAO_IDLE;
        ex_cnt_r[p] <= '0;
        en_cnt_r[p] <= '0;
        bq_r[p] <= '0;
      end
    end else begin
      for (int p = 0; p < NP; p++) begin
        snd_r[p] <= 1'b0;
        case (ph_r[p])
          PAO_IDLE: begin
            if (arm_go[p]) begin
              ph_r[p] <= PAO_EXIT;
              armed_r[p] <= 1'b1;
              byp_r[p] <= 1'b0;
              ex_cnt_r[p] <= EXIT_S;
            end
          end
          PAO_EXIT: begin
            if (exrst_r && d_door[p] && !s2_door[p]) begin
              ex_cnt_r[p] <= EXIT_RST_S;
            end else if (s_tick && ex_cnt_r[p] <= 7'd1) begin
              ph_r[p] <= PAO_ARMED;
              byp_r[p] <= exerr_r && (s2_door[p] || s2_int[p]);
            end else if (s_tick) begin
              ex_cnt_r[p] <= ex_cnt_r[p] - 7'd1;
            end
          end
          PAO_ARMED: begin
            if (s2_door[p] && !d_door[p] && !byp_r[p]) begin
              ph_r[p] <= PAO_ENTRY;
              en_cnt_r[p] <= ENTRY_S;
              bq_r[p] <= '0;
            end
          end
          PAO_ENTRY: begin
            if (s_tick && en_cnt_r[p] != '0) en_cnt_r[p] <= en_cnt_r[p] - 7'd1;
            if (s_tick && en_cnt_r[p] <= 7'd1) ph_r[p] <= PAO_ARMED;
            if (q_tick && bq_r[p] != 4'hF) bq_r[p] <= bq_r[p] + 4'h1;
            if (opt_r[p].entry_warn) snd_r[p] <= (qph_r == 2'h0);
            else snd_r[p] <= (bq_r[p] < BEEP_QTRS) && !bq_r[p][0];
          end
          default: ph_r[p] <= PAO_IDLE;
        endcase
        if (dis_go[p]) begin
          ph_r[p] <= PAO_IDLE;
          armed_r[p] <= 1'b0;
          byp_r[p] <= 1'b0;
          snd_r[p] <= 1'b0;
        end
      end
    end
  end
  // ==========================================================
  // alarm and restore reporting
  logic [NP-1:0] alm_hit, rst_hit;
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      alm_hit[p] = s2_bz[p] && !d_bz[p] && (armed_r[p] || s2_24[p]);
      rst_hit[p] = 1'b0;
      if (seen_r[p]) begin
        case (rmode_r)
          RMODE_NOW: rst_hit[p] = d_bz[p] && !s2_bz[p];
          RMODE_BELL: rst_hit[p] = s2_bell[p] && !d_bell[p] && !s2_bz[p];
          RMODE_DISARM: rst_hit[p] = dis_go[p] && !s2_bz[p];
          default: rst_hit[p] = 1'b0;
        endcase
      end
    end
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dly_r <= '0;
      seen_r <= '0;
      rstd_r <= '0;
      rep_a_r <= '0;
      rep_r_r <= '0;
      for (int p = 0; p < NP; p++) dly_cnt_r[p] <= '0;
    end else begin
      for (int p = 0; p < NP; p++) begin
        rep_a_r[p] <= 1'b0;
        rep_r_r[p] <= rst_hit[p];
        rstd_r[p] <= 1'b0;
        if (rst_hit[p]) seen_r[p] <= 1'b0;
        if (alm_hit[p]) begin
          seen_r[p] <= 1'b1;
          if (opt_r[p].burg_dly && !s2_24[p]) begin
            dly_r[p] <= 1'b1;
            dly_cnt_r[p] <= BURG_DLY_S;
          end else begin
            rep_a_r[p] <= 1'b1;
          end
        end else if (dly_r[p] && s_tick) begin
          if (dly_cnt_r[p] <= 7'd1) begin
            dly_r[p] <= 1'b0;
            rep_a_r[p] <= 1'b1;
          end else begin
            dly_cnt_r[p] <= dly_cnt_r[p] - 7'd1;
          end
        end
      end
    end
  end
  // ==========================================================
  // sticky events and interrupt
  // bypass history for the rising-edge event
  always_ff @(posedge aclk) begin
    if (!aresetn) byp_d_r <= '0;
    else byp_d_r <= byp_r;
  end
  assign ev_set = {byp_r & ~byp_d_r, refuse, rst_hit, alm_hit};
  always_ff @(posedge aclk) begin
    if (!aresetn) evt_r <= '0;
    else evt_r <= (evt_r & ~ev_clr) | ev_set; // set wins over clear
  end
  // ==========================================================
  // read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rv_r <= 1'b0;
      rd_r <= '0;
      rresp_r <= RESP_OKAY;
    end else if (s_arvalid && !rv_r) begin
      rv_r <= 1'b1;
      rresp_r <= RESP_OKAY;
      case (s_araddr)
        CFG_OFF: rd_r <= 32'({exrst_r, exerr_r, lob_r, rmode_r});
        OPT_OFF: rd_r <= 32'({opt_r[1], opt_r[0]});
        ACC0_OFF: rd_r <= 32'({empty_r[0], acc_r[0]});
        ACC1_OFF: rd_r <= 32'({empty_r[1], acc_r[1]});
        STAT_OFF: rd_r <= 32'({byp_r, 4'h0, armed_r});
        EVT_OFF: rd_r <= 32'(evt_r);
        EVEN_OFF: rd_r <= 32'(even_r);
        CMD_OFF, EVCLR_OFF: rd_r <= '0;
        default: begin
          rd_r <= '0;
          rresp_r <= RESP_SLVERR;
        end
      endcase
    end else if (rv_r && s_rready) begin
      rv_r <= 1'b0;
    end
  end
  // ==========================================================
  // output flops
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
      armed <= '0;
      sounder <= '0;
      bypass <= '0;
      rep_alarm <= '0;
      rep_restore <= '0;
    end else begin
      irq <= |(evt_r & even_r);
      armed <= armed_r;
      sounder <= snd_r;
      bypass <= byp_r;
      rep_alarm <= rep_a_r;
      rep_restore <= rep_r_r;
    end
  end
  assign s_awready = !aw_ok_r;
  assign s_wready = !w_ok_r;
  assign s_bvalid = bv_r;
  assign s_bresp = bresp_r;
  assign s_arready = !rv_r;
  assign s_rvalid = rv_r;
  assign s_rdata = rd_r;
  assign s_rresp = rresp_r;
  // ==========================================================
  // assertions
  sequence dly_arm_s;
    alm_hit[0] && opt_r[0].burg_dly && !s2_24[0];
  endsequence
  beep_stop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ph_r[1] == PAO_ENTRY && !opt_r[1].entry_warn && bq_r[1] >= BEEP_QTRS |=> !snd_r[1])
    else $error("beep after third short beep");
  burg_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    dly_arm_s |=> dly_r[0] && !rep_a_r[0] && dly_cnt_r[0] == BURG_DLY_S)
    else $error("burglary report not held");
  rst_now_a: assert property (@(posedge aclk) disable iff (!aresetn)
    seen_r[0] && rmode_r == RMODE_NOW && $fell(s2_bz[0]) |=> rep_r_r[0])
    else $error("instant restore missing");
  rst_bell_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rep_r_r[0] && rmode_r == RMODE_BELL |-> $past(s2_bell[0]) && !$past(s2_bz[0]))
    else $error("restore before bell timeout");
  rst_dis_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rep_r_r[0] && rmode_r == RMODE_DISARM |-> $past(dis_go[0]))
    else $error("restore without disarm");
  acct_erase_a: assert property (@(posedge aclk) disable iff (!aresetn)
    cmd_era[0] |=> empty_r[0] && acc_r[0].d0 == DIG_RST)
    else $error("account not erased");
  lobby_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lob_en && $rose(armed_r[lp]) |-> $past(lob_ok) || $past(dis_go[lp]))
    else $error("lobby armed with affecting partition disarmed");
  lobby_drop_a: assert property (@(posedge aclk) disable iff (!aresetn)
    lob_r == 2'h2 && cmd_dis[0] && opt_r[0].affects |=> !armed_r[1])
    else $error("lobby not disarmed");
  exit_reload_a: assert property (@(posedge aclk) disable iff (!aresetn)
    ph_r[0] == PAO_EXIT && exrst_r && $fell(s2_door[0]) && !dis_go[0]
    |=> ex_cnt_r[0] == EXIT_RST_S)
    else $error("exit delay not reloaded");
endmodule : pao_top
`default_nettype wire
